// ---- rtl/umd_defines.svh ----
// Constants of the LED bypass dimming controller: offsets, fields, timing.
// Assumes inclusion by bare name from the design files.
`ifndef UMD_DEFINES_SVH
`define UMD_DEFINES_SVH
`define UMD_SYNC         8'h79
`define UMD_ACK          8'hC3
`define UMD_GLOBAL_ID    6'h3F
`define UMD_REG_GEN      8'h03
`define UMD_REG_SERIAL   8'h04
`define UMD_REG_STATUS   8'h08
`define UMD_BASE_TARGET  4'h1
`define UMD_BASE_PHASE   4'h2
`define UMD_BASE_HOLD    4'h3
`define UMD_BASE_DUTY    4'h5
`define UMD_GEN_RST      13'h0000
`define UMD_F_CLK        1:0
`define UMD_F_DIV        3:2
`define UMD_F_SHORT_LO   9:7
`define UMD_F_SHORT_HI   12:10
`define UMD_F_FADE       12
`define UMD_ST_TIMEOUT   0
`define UMD_ST_CRC       1
`define UMD_ST_PAR       2
`define UMD_ST_STOP      3
`define UMD_SYS_KHZ      64'h186A0
`define UMD_OSC_KHZ      64'h4000
`define UMD_NCO_INC      16'((64'h2 * `UMD_OSC_KHZ * 64'h10000) / `UMD_SYS_KHZ)
`define UMD_MIN_KBPS     64'hA
`define UMD_MAX_BIT_CYC  (`UMD_SYS_KHZ / `UMD_MIN_KBPS)
`define UMD_TIMEOUT_BITS 5'h10
`define UMD_FADE_SHIFT   4
`define UMD_DIM_BASE     5'h2
`endif

// ---- rtl/umd_pkg.sv ----
// Types shared by the dimming controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package umd_pkg;
  typedef enum logic [5:0] {
    P_IDLE = 6'h01, P_ADDR = 6'h02, P_REG = 6'h04,
    P_DLO = 6'h08, P_LAST = 6'h10, P_RESP = 6'h20
  } umd_pkt_t;
  typedef enum logic [2:0] {
    R_IDLE = 3'h1, R_MEAS = 3'h2, R_DATA = 3'h4
  } umd_rx_t;
endpackage : umd_pkg

// ---- rtl/umd_link_if.sv ----
// Byte link between the packet controller and the serial engine.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface umd_link_if;
  logic       rxValid;
  logic [7:0] rxByte;
  logic       rxParErr;
  logic       rxStopErr;
  logic       rxTimeout;
  logic       pktActive;
  logic       txReq;
  logic [7:0] txByte;
  logic       txBusy;
  modport uart (output rxValid, rxByte, rxParErr, rxStopErr, rxTimeout,
                txBusy, input pktActive, txReq, txByte);
  modport ctrl (input rxValid, rxByte, rxParErr, rxStopErr, rxTimeout,
                txBusy, output pktActive, txReq, txByte);
endinterface : umd_link_if

// ---- rtl/umd_uart.sv ----
// Autobaud serial engine: measures each packet's first start bit,
// receives 11-bit frames and sends replies on an open-drain line.
// Assumes rxIn synchronous to clk_sys and idle high.
`timescale 1ns/1ps
`include "umd_defines.svh"
module umd_uart #(
  parameter int BW          = 14,
  parameter int MAX_BIT_CYC = 10000
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Serial pins
  input  wire logic rxIn,
  output logic      txOe,
  // Controller side
  umd_link_if.uart  link
);
  typedef struct packed {
    umd_pkg::umd_rx_t st;
    logic [BW-1:0]    cnt;
    logic [BW-1:0]    bitLen;
    logic [BW-1:0]    idleCnt;
    logic [4:0]       idleBits;
    logic [3:0]       idx;
    logic [9:0]       sh;
    logic             valid;
    logic             parErr;
    logic             stopErr;
    logic             timeout;
    logic [7:0]       rxB;
    logic             txOn;
    logic [BW-1:0]    txCnt;
    logic [3:0]       txIdx;
    logic [10:0]      txSh;
    logic             txOe;
  } umd_uart_t;
  localparam umd_uart_t RST = '{st: umd_pkg::R_IDLE, txSh: 11'h7FF,
                                default: '0};
  umd_uart_t s_q;
  umd_uart_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.timeout = 1'b0;
    case (s_q.st)
      umd_pkg::R_IDLE:
      begin
        s_d.idx = 4'h0;
        if (!rxIn)
        begin
          s_d.idleBits = 5'h0;
          s_d.idleCnt = '0;
          if (link.pktActive)
          begin
            s_d.st = umd_pkg::R_DATA;
            s_d.cnt = s_q.bitLen + (s_q.bitLen >> 1);
          end
          else
          begin
            s_d.st = umd_pkg::R_MEAS;
            s_d.cnt = BW'(1);
          end
        end
        else if (link.pktActive)
        begin
          // Idle line inside a packet counts whole bit lengths
          if (s_q.idleCnt >= s_q.bitLen - 1'b1)
          begin
            s_d.idleCnt = '0;
            s_d.idleBits = s_q.idleBits + 1'b1;
          end
          else
            s_d.idleCnt = s_q.idleCnt + 1'b1;
          if (s_q.idleBits == `UMD_TIMEOUT_BITS)
          begin
            s_d.timeout = 1'b1;
            s_d.idleBits = 5'h0;
          end
        end
        else
          s_d.idleBits = 5'h0;
      end
      umd_pkg::R_MEAS:
        if (rxIn)
        begin
          s_d.bitLen = s_q.cnt;
          s_d.cnt = s_q.cnt >> 1;
          s_d.st = umd_pkg::R_DATA;
        end
        else if (s_q.cnt == BW'(MAX_BIT_CYC))
          s_d.st = umd_pkg::R_IDLE;
        else
          s_d.cnt = s_q.cnt + 1'b1;
      umd_pkg::R_DATA:
        if (s_q.cnt == '0)
        begin
          s_d.sh = {rxIn, s_q.sh[9:1]};
          s_d.cnt = s_q.bitLen - 1'b1;
          s_d.idx = s_q.idx + 1'b1;
          if (s_q.idx == 4'h9)
          begin
            s_d.st = umd_pkg::R_IDLE;
            s_d.valid = 1'b1;
            s_d.rxB = s_d.sh[7:0];
            s_d.parErr = ^s_d.sh[8:0];
            s_d.stopErr = !rxIn;
          end
        end
        else
          s_d.cnt = s_q.cnt - 1'b1;
      default: s_d.st = umd_pkg::R_IDLE;
    endcase
    if (!s_q.txOn)
    begin
      if (link.txReq)
      begin
        s_d.txOn = 1'b1;
        s_d.txSh = {1'b1, ^link.txByte, link.txByte, 1'b0};
        s_d.txCnt = s_q.bitLen - 1'b1;
        s_d.txIdx = 4'h0;
      end
    end
    else if (s_q.txCnt == '0)
    begin
      s_d.txSh = {1'b1, s_q.txSh[10:1]};
      s_d.txCnt = s_q.bitLen - 1'b1;
      s_d.txIdx = s_q.txIdx + 1'b1;
      if (s_q.txIdx == 4'hA)
        s_d.txOn = 1'b0;
    end
    else
      s_d.txCnt = s_q.txCnt - 1'b1;
    s_d.txOe = s_d.txOn && !s_d.txSh[0];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s_q <= RST;
    else
      s_q <= s_d;
  end

  assign link.rxValid   = s_q.valid;
  assign link.rxByte    = s_q.rxB;
  assign link.rxParErr  = s_q.parErr;
  assign link.rxStopErr = s_q.stopErr;
  assign link.rxTimeout = s_q.timeout;
  assign link.txBusy    = s_q.txOn;
  assign txOe           = s_q.txOe;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_tx_opendrain: assert property (txOe |-> s_q.txOn)
    else $error("tx driven outside a reply");
  a_tx_start_low: assert property (link.txReq && !s_q.txOn |=> txOe)
    else $error("start bit not driven low");
  a_rx_timeout: assert property (link.rxTimeout |->
      $past(link.pktActive))
    else $error("timeout outside a packet");
  c_frame_rx: cover property (link.rxValid && !link.rxParErr);
endmodule : umd_uart

// ---- rtl/umd_top.sv ----
// Packet controller, register file and six-switch PWM/fade engine.
// Assumes synchronous straps and pins; power-on reset drives nrst.
`timescale 1ns/1ps
`include "umd_defines.svh"
module umd_top #(
  parameter int BW          = 14,
  parameter int MAX_BIT_CYC = int'(`UMD_MAX_BIT_CYC),
  parameter int HOLD_W      = 8
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Identity straps
  input  wire logic [3:0] idLowStrap,
  input  wire logic [3:0] idHighStrap,
  // Serial pins
  input  wire logic       rxIn,
  output logic            txOut,
  output logic            txOe,
  // PWM clock pin
  input  wire logic       pwmClkIn,
  output logic            pwmClkOut,
  output logic            pwmClkOe,
  // Switches and fault detectors
  output logic [5:0]      switchClosed,
  output logic [5:0]      ledDetEn,
  output logic [5:0]      traceDetEn,
  output logic [2:0]      shortLimitLow,
  output logic [2:0]      shortLimitHigh
);
  typedef struct packed {
    umd_pkg::umd_pkt_t       pst;
    logic                    idDone;
    logic [5:0]              id;
    logic                    isRead;
    logic                    match;
    logic                    ackable;
    logic [7:0]              regAddr;
    logic [7:0]              dataLo;
    logic [2:0]              crc;
    logic [12:0]             resp;
    logic [2:0]              respCrc;
    logic [1:0]              respLeft;
    logic [1:0]              respIdx;
    logic                    txReq;
    logic [7:0]              txByte;
    logic [12:0]             gen;
    logic [5:0]              cluster;
    logic [3:0]              status;
    logic [5:0][12:0]        target;
    logic [5:0][11:0]        phase;
    logic [5:0][11:0]        cur;
    logic [5:0][HOLD_W-1:0]  hold;
    logic [5:0][HOLD_W-1:0]  holdCnt;
    logic [15:0]             nco;
    logic                    pclk;
    logic                    extPrev;
    logic                    pinOe;
    logic [3:0]              pre;
    logic [11:0]             tb;
    logic [5:0]              closed;
    logic [5:0]              ledDet;
    logic [5:0]              trDet;
  } umd_top_t;
  localparam umd_top_t RST = '{pst: umd_pkg::P_IDLE, gen: `UMD_GEN_RST,
                               closed: 6'h3F, default: '0};
  umd_top_t s_q;
  umd_top_t s_d;
  umd_link_if link ();

  umd_uart #(.BW(BW), .MAX_BIT_CYC(MAX_BIT_CYC)) u_uart (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .rxIn    (rxIn),
    .txOe    (txOe),
    .link    (link)
  );

  function automatic logic [2:0] crcUpd(input logic [2:0] c,
                                        input logic [7:0] d,
                                        input int n);
    logic [2:0] r;
    logic       fb;
    r = c;
    for (int i = 0; i < 8; i++)
      if (i < n)
      begin
        fb = r[2] ^ d[i];
        r = {r[1], r[0] ^ fb, fb};
      end
    return r;
  endfunction : crcUpd

  function automatic logic regHit(input logic [7:0] a,
                                  input logic [3:0] base);
    return a[7:4] == base && a[3:0] < 4'h6;
  endfunction : regHit

  function automatic logic [11:0] fadeStep(input logic [11:0] c,
                                           input logic [11:0] t);
    logic [11:0] st;
    st = c >> `UMD_FADE_SHIFT;
    if (st == 12'h000)
      st = 12'h001;
    if (t > c)
      return (t - c <= st) ? t : c + st;
    return (c - t <= st) ? t : c - st;
  endfunction : fadeStep

  always_comb
  begin
    logic [12:0] rv;
    logic [12:0] wd;
    logic [7:0]  b;
    logic [2:0]  ai;
    logic [2:0]  c;
    logic        wr;
    logic        carry;
    logic        tick;
    logic        tbTick;
    rv = 13'h0000;
    wd = {link.rxByte[4:0], s_q.dataLo};
    b = link.rxByte;
    ai = s_q.regAddr[2:0];
    c = 3'h0;
    wr = 1'b0;
    carry = 1'b0;
    tick = 1'b0;
    tbTick = 1'b0;
    s_d = s_q;
    s_d.txReq = 1'b0;
    if (!s_q.idDone)
    begin
      s_d.id = {idHighStrap[1:0], idLowStrap};
      s_d.idDone = 1'b1;
    end
    // Read data for the addressed register; unmapped reads as zero
    if (s_q.regAddr == `UMD_REG_GEN)
      rv = s_q.gen;
    else if (s_q.regAddr == `UMD_REG_SERIAL)
      rv = {7'h00, s_q.cluster};
    else if (s_q.regAddr == `UMD_REG_STATUS)
      rv = {9'h000, s_q.status};
    else if (regHit(s_q.regAddr, `UMD_BASE_TARGET))
      rv = s_q.target[ai];
    else if (regHit(s_q.regAddr, `UMD_BASE_PHASE))
      rv = {1'b0, s_q.phase[ai]};
    else if (regHit(s_q.regAddr, `UMD_BASE_HOLD))
      rv = 13'(s_q.hold[ai]);
    else if (regHit(s_q.regAddr, `UMD_BASE_DUTY))
      rv = {1'b0, s_q.cur[ai]};
    if (link.rxValid && s_q.pst != umd_pkg::P_RESP)
    begin
      if (link.rxParErr || link.rxStopErr)
      begin
        s_d.status[`UMD_ST_PAR] = s_q.status[`UMD_ST_PAR] | link.rxParErr;
        s_d.status[`UMD_ST_STOP] = s_q.status[`UMD_ST_STOP]
                                 | link.rxStopErr;
        s_d.pst = umd_pkg::P_IDLE;
      end
      else
        case (s_q.pst)
          umd_pkg::P_IDLE:
            if (b == `UMD_SYNC)
            begin
              s_d.pst = umd_pkg::P_ADDR;
              s_d.crc = 3'h0;
            end
          umd_pkg::P_ADDR:
          begin
            s_d.isRead = b[0];
            s_d.ackable = !b[7];
            s_d.match = b[7] ? (!b[0] && (b[6:1] == s_q.cluster
                                || b[6:1] == `UMD_GLOBAL_ID))
                             : b[6:1] == s_q.id;
            s_d.crc = crcUpd(s_q.crc, b, 8);
            s_d.pst = umd_pkg::P_REG;
          end
          umd_pkg::P_REG:
          begin
            s_d.regAddr = b;
            s_d.crc = crcUpd(s_q.crc, b, 8);
            s_d.pst = s_q.isRead ? umd_pkg::P_LAST : umd_pkg::P_DLO;
          end
          umd_pkg::P_DLO:
          begin
            s_d.dataLo = b;
            s_d.crc = crcUpd(s_q.crc, b, 8);
            s_d.pst = umd_pkg::P_LAST;
          end
          umd_pkg::P_LAST:
          begin
            c = crcUpd(s_q.crc, {3'h0, b[4:0]}, 5);
            s_d.pst = umd_pkg::P_IDLE;
            if (c != b[7:5])
              s_d.status[`UMD_ST_CRC] = 1'b1;
            else if (s_q.match && s_q.isRead)
            begin
              s_d.resp = rv;
              s_d.respCrc = crcUpd(crcUpd(3'h0, rv[7:0], 8),
                                   {3'h0, rv[12:8]}, 5);
              s_d.respLeft = 2'h3;
              s_d.respIdx = 2'h0;
              s_d.pst = umd_pkg::P_RESP;
            end
            else if (s_q.match)
            begin
              wr = 1'b1;
              s_d.respLeft = 2'h1;
              s_d.respIdx = 2'h0;
              if (s_q.ackable)
                s_d.pst = umd_pkg::P_RESP;
            end
          end
          default: s_d.pst = umd_pkg::P_IDLE;
        endcase
    end
    if (wr)
    begin
      if (s_q.regAddr == `UMD_REG_GEN)
        s_d.gen = wd;
      else if (s_q.regAddr == `UMD_REG_SERIAL)
        s_d.cluster = wd[5:0];
      else if (s_q.regAddr == `UMD_REG_STATUS)
        s_d.status = s_q.status & ~wd[3:0];
      else if (regHit(s_q.regAddr, `UMD_BASE_TARGET))
        s_d.target[ai] = wd;
      else if (regHit(s_q.regAddr, `UMD_BASE_PHASE))
        s_d.phase[ai] = wd[11:0];
      else if (regHit(s_q.regAddr, `UMD_BASE_HOLD))
        s_d.hold[ai] = wd[HOLD_W-1:0];
    end
    if (link.rxTimeout && s_q.pst != umd_pkg::P_RESP)
    begin
      s_d.status[`UMD_ST_TIMEOUT] = 1'b1;
      s_d.pst = umd_pkg::P_IDLE;
    end
    if (s_q.pst == umd_pkg::P_RESP && !s_q.txReq && !link.txBusy)
    begin
      if (s_q.respLeft == 2'h0)
        s_d.pst = umd_pkg::P_IDLE;
      else
      begin
        s_d.txReq = 1'b1;
        s_d.txByte = (s_q.respIdx == 2'h0) ? `UMD_ACK
                   : (s_q.respIdx == 2'h1) ? s_q.resp[7:0]
                   : {s_q.respCrc, s_q.resp[12:8]};
        s_d.respIdx = s_q.respIdx + 2'h1;
        s_d.respLeft = s_q.respLeft - 2'h1;
      end
    end
    // PWM clock: internal oscillator or sampled external pin
    {carry, s_d.nco} = {1'b0, s_q.nco} + {1'b0, `UMD_NCO_INC};
    if (carry)
      s_d.pclk = !s_q.pclk;
    s_d.extPrev = pwmClkIn;
    tick = s_q.gen[1] ? (pwmClkIn && !s_q.extPrev)
                      : (carry && !s_q.pclk);
    s_d.pinOe = s_q.gen[`UMD_F_CLK] == 2'h1 && !s_d.pclk;
    if (tick)
    begin
      if (s_q.pre == 4'((`UMD_DIM_BASE << s_q.gen[`UMD_F_DIV]) - 5'h1))
      begin
        s_d.pre = 4'h0;
        tbTick = 1'b1;
      end
      else
        s_d.pre = s_q.pre + 4'h1;
    end
    if (tbTick)
    begin
      s_d.tb = s_q.tb + 12'h001;
      for (int i = 0; i < 6; i++)
      begin
        if (s_q.cur[i] == 12'h000)
          s_d.closed[i] = 1'b1;
        else if (s_q.closed[i] && s_d.tb == s_q.phase[i])
          s_d.closed[i] = 1'b0;
        else if (!s_q.closed[i] && 12'(s_d.tb - s_q.phase[i]) > s_q.cur[i])
          s_d.closed[i] = 1'b1;
        if (s_q.tb == 12'hFFF)
        begin
          if (!s_q.target[i][`UMD_F_FADE])
            s_d.cur[i] = s_q.target[i][11:0];
          else if (s_q.cur[i] != s_q.target[i][11:0])
          begin
            if (s_q.holdCnt[i] + 1'b1 >= s_q.hold[i])
            begin
              s_d.holdCnt[i] = '0;
              s_d.cur[i] = fadeStep(s_q.cur[i],
                                    s_q.target[i][11:0]);
            end
            else
              s_d.holdCnt[i] = s_q.holdCnt[i] + 1'b1;
          end
        end
      end
    end
    for (int i = 0; i < 6; i++)
    begin
      s_d.ledDet[i] = !s_d.closed[i];
      s_d.trDet[i] = s_d.closed[i] && s_d.cur[i] != 12'hFFF;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s_q <= RST;
    else
      s_q <= s_d;
  end

  assign link.pktActive = s_q.pst != umd_pkg::P_IDLE
                       && s_q.pst != umd_pkg::P_RESP;
  assign link.txReq     = s_q.txReq;
  assign link.txByte    = s_q.txByte;
  assign txOut          = 1'b0;
  assign pwmClkOut      = 1'b0;
  assign pwmClkOe       = s_q.pinOe;
  assign switchClosed   = s_q.closed;
  assign ledDetEn       = s_q.ledDet;
  assign traceDetEn     = s_q.trDet;
  assign shortLimitLow  = s_q.gen[`UMD_F_SHORT_LO];
  assign shortLimitHigh = s_q.gen[`UMD_F_SHORT_HI];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_id_capture: assert property ($rose(s_q.idDone) |->
      s_q.id == $past({idHighStrap[1:0], idLowStrap}))
    else $error("identity not formed from straps");
  a_clk_pin_dir: assert property (pwmClkOe |->
      $past(s_q.gen[1:0]) == 2'h1)
    else $error("clock pin driven outside master mode");
  a_switch_opens: assert property ($fell(switchClosed[0]) |->
      s_q.tb == s_q.phase[0] && $past(s_q.cur[0]) != 12'h000)
    else $error("switch opened away from its phase");
  a_fade_direction: assert property ($changed(s_q.cur[0])
      && $past(s_q.target[0][12]) |-> ($past(s_q.cur[0])
      < $past(s_q.target[0][11:0])) == (s_q.cur[0] > $past(s_q.cur[0])))
    else $error("fade moved away from target");
  a_fade_nover: assert property ($changed(s_q.cur[0])
      && $past(s_q.target[0][12]) && $past(s_q.cur[0])
      < $past(s_q.target[0][11:0]) |-> s_q.cur[0] <= s_q.target[0][11:0])
    else $error("fade overshot target");
  a_led_gate: assert property (ledDetEn[0] |-> !switchClosed[0])
    else $error("LED check while switch closed");
  a_bad_silent: assert property (link.rxValid
      && s_q.pst != umd_pkg::P_RESP
      && (link.rxParErr || link.rxStopErr) |=> !link.txReq [*3])
    else $error("reply after a bad frame");
  a_ack_first: assert property ($rose(s_q.pst == umd_pkg::P_RESP) |->
      ##1 link.txReq && link.txByte == `UMD_ACK)
    else $error("reply does not open with acknowledge");
  c_read_reply: cover property (s_q.respIdx == 2'h3 && link.txReq);
  c_write_ack: cover property ($rose(s_q.pst == umd_pkg::P_RESP)
                               && !s_q.isRead);
  c_fade_step: cover property ($changed(s_q.cur[0]) && s_q.target[0][12]);
  c_timeout: cover property (link.rxTimeout);
endmodule : umd_top

// ---- test/umd_master_model.sv ----
// Serial master model: sends request frames and collects reply frames.
// Assumes the reply line is pulled up, so its level is the inverse of txOe.
`timescale 1ns/1ps
module umd_master_model #(
  parameter int BIT = 40
) (
  // Clock and serial lines
  input  wire logic clk_sys,
  input  wire logic txOe,
  output logic      rxIn
);
  logic parFlip;
  initial rxIn = 1'b1;
  initial parFlip = 1'b0;
  task automatic sendByte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b ^ parFlip, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxIn = f[i];
      repeat (i == 10 ? BIT * 3 / 4 : BIT) @(posedge clk_sys);
      #1;
    end
  endtask : sendByte
  task automatic getByte(output logic [7:0] b, output logic ok);
    logic [10:0] f;
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (txOe !== 1'b1 && n < 2000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n < 2000)
    begin
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 11; i++)
      begin
        f[i] = ~txOe;
        if (i < 10) repeat (BIT) @(posedge clk_sys);
      end
      ok = f[0] == 1'b0 && f[10] && f[9] == ^f[8:1];
      b = f[8:1];
    end
    #1;
  endtask : getByte
endmodule : umd_master_model

// ---- test/uart_matrix_dimming_controller_tb.sv ----
// Self-checking bench: register traffic over the serial link, refusals,
// and switch 0 opening at the start of a PWM cycle on an external clock.
// Assumes the master model of umd_master_model.sv.
`timescale 1ns/1ps
module uart_matrix_dimming_controller_tb;
  logic        clk_sys, nrst, rxIn, txOut, txOe, extRun;
  logic        pwmClkIn, pwmClkOut, pwmClkOe;
  logic [3:0]  idLowStrap, idHighStrap;
  logic [5:0]  switchClosed, ledDetEn, traceDetEn, myId;
  logic [2:0]  shortLimitLow, shortLimitHigh;
  logic [31:0] seed;
  logic [12:0] gen;
  logic [7:0]  rb;
  logic        rok;
  int          miscompares, num_checks;
  umd_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .idLowStrap(idLowStrap),
    .idHighStrap(idHighStrap), .rxIn(rxIn), .txOut(txOut), .txOe(txOe),
    .pwmClkIn(pwmClkIn), .pwmClkOut(pwmClkOut), .pwmClkOe(pwmClkOe),
    .switchClosed(switchClosed), .ledDetEn(ledDetEn),
    .traceDetEn(traceDetEn), .shortLimitLow(shortLimitLow),
    .shortLimitHigh(shortLimitHigh));
  umd_master_model m (.clk_sys(clk_sys), .txOe(txOe), .rxIn(rxIn));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Serial CRC, first bit of the stream in bit 0
  function automatic logic [2:0] crc3(input logic [28:0] s, input int n);
    logic [2:0] c;
    logic       fb;
    c = 3'h0;
    for (int i = 0; i < n; i++)
    begin
      fb = c[2] ^ s[i];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction : crc3
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [7:0] r,
                    input logic [12:0] v, input logic [2:0] flip,
                    input logic ack);
    logic [7:0] b;
    logic       ok;
    m.sendByte(8'h79);
    m.sendByte({a, 1'b0});
    m.sendByte(r);
    m.sendByte(v[7:0]);
    m.sendByte({crc3({v, r, a, 1'b0}, 29) ^ flip, v[12:8]});
    m.getByte(b, ok);
    check(13'(ok), 13'(ack));
    if (ack) check(13'(b), 13'h0C3);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] r,
                    input logic [12:0] v, input logic ack);
    logic [7:0] b0, b1, b2;
    logic       ok;
    m.sendByte(8'h79);
    m.sendByte({a, 1'b1});
    m.sendByte(r);
    m.sendByte({crc3(29'({r, a, 1'b1}), 21), 5'h00});
    m.getByte(b0, ok);
    check(13'(ok), 13'(ack));
    if (ack)
    begin
      m.getByte(b1, ok);
      m.getByte(b2, ok);
      check({b2[4:0], b1}, v);
      check(13'({b0, b2[7:5]}), 13'({8'hC3, crc3(29'(v), 13)}));
    end
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // External PWM clock: one rising edge every two system cycles
  always @(posedge clk_sys) pwmClkIn <= extRun & ~pwmClkIn;
  initial
  begin
    #980000;
    miscompares++;
    print_verdict();
  end
  initial
  begin
    nrst = 1'b0;
    extRun = 1'b0;
    pwmClkIn = 1'b0;
    seed = lfsr(32'h6DEC84D4);
    idLowStrap = seed[3:0];
    idHighStrap = seed[7:4];
    myId = {idHighStrap[1:0], idLowStrap};
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check(13'(switchClosed), 13'h003F);
    check(13'({pwmClkOe, txOe, shortLimitHigh, shortLimitLow}), 13'h0);
    check(13'(traceDetEn), 13'h003F);
    check(13'({txOut, pwmClkOut}), 13'h0);
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      gen = {seed[12:2], 2'h0};
      wr({1'b0, myId}, 8'h03, gen, 3'h0, 1'b1);
      check(13'({shortLimitHigh, shortLimitLow}), 13'(gen[12:7]));
      rd({1'b0, myId}, 8'h03, gen, 1'b1);
    end
    wr({1'b0, myId}, 8'h03, ~gen & 13'h1FFC, 3'h1, 1'b0);
    wr({1'b0, myId ^ 6'h01}, 8'h03, ~gen & 13'h1FFC, 3'h0, 1'b0);
    rd({1'b1, myId}, 8'h03, gen, 1'b0);
    // Parity error on the last frame: packet dropped, no reply
    m.sendByte(8'h79);
    m.sendByte({1'b0, myId, 1'b0});
    m.sendByte(8'h03);
    m.sendByte(8'h00);
    m.parFlip = 1'b1;
    m.sendByte({crc3({13'h0000, 8'h03, 1'b0, myId, 1'b0}, 29), 5'h00});
    m.parFlip = 1'b0;
    m.getByte(rb, rok);
    check(13'(rok), 13'h0);
    // Packet stalls after its address frame
    m.sendByte(8'h79);
    m.sendByte({1'b0, myId, 1'b0});
    m.getByte(rb, rok);
    check(13'(rok), 13'h0);
    rd({1'b0, myId}, 8'h08, 13'h0007, 1'b1);
    check(13'({shortLimitHigh, shortLimitLow}), 13'(gen[12:7]));
    wr({1'b1, 6'h3F}, 8'h03, 13'h1C01, 3'h0, 1'b0);
    check(13'({shortLimitHigh, shortLimitLow}), 13'h0038);
    for (int n = 0; n < 50 && pwmClkOe !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    check(13'(pwmClkOe), 13'h1);
    wr({1'b0, myId}, 8'h03, 13'h0002, 3'h0, 1'b1);
    check(13'(pwmClkOe), 13'h0);
    extRun = 1'b1;
    wr({1'b0, myId}, 8'h10, 13'h0800, 3'h0, 1'b1);
    for (int n = 0; n < 40000 && switchClosed[0] !== 1'b0; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    check(13'({switchClosed, ledDetEn}), 13'({6'h3E, 6'h01}));
    rd({1'b0, myId}, 8'h50, 13'h0800, 1'b1);
    print_verdict();
  end
endmodule : uart_matrix_dimming_controller_tb
